// [design/supply_fault_status_regs.sv]
// Purpose: Sticky supply and regulator fault flags with host register access and alert pin
// Assumes: Register requests come from same-clock command decoding logic
// Notes:   Read data and alert are registered; a set always beats a same-cycle clear
`timescale 1ns/100ps
module supply_fault_status_regs (
  input  wire logic                          sys_clk_in,
  input  wire logic                          rst_in,
  input  wire supply_fault_pkg::fault_cond_s fault_in,
  input  wire supply_fault_pkg::reg_req_s    req_in,
  output logic [7:0]                         rdata_out,
  output logic [7:0]                         supply_rail_fault_status_out,
  output logic [7:0]                         regulator_fault_status_out,
  output logic                               summary_alert_out,
  output logic                               alert_out_n
);

  supply_fault_pkg::fault_state_s st_reg;
  supply_fault_pkg::fault_state_s st_next;
  logic [7:0] rail_set;
  logic [7:0] regl_set;
  logic [7:0] rail_keep;
  logic [7:0] regl_keep;
  logic       wr_rail;
  logic       wr_regl;

  always_comb begin
    st_next = st_reg;
    // Comparators are asynchronous, so two stages before use
    st_next.sync1 = fault_in;
    st_next.sync2 = st_reg.sync1;
    st_next.por_pend = 1'b0;
    wr_rail = req_in.wr && (req_in.addr == supply_fault_pkg::SUPPLY_RAIL_FAULT_STATUS_ADDR);
    wr_regl = req_in.wr && (req_in.addr == supply_fault_pkg::REGULATOR_FAULT_STATUS_ADDR);
    rail_set = 8'h00;
    rail_set[supply_fault_pkg::RAIL_AUX_6V_OV_BIT]  = st_reg.sync2.aux_6v_rail_ov;
    rail_set[supply_fault_pkg::RAIL_AUX_6V_UV_BIT]  = st_reg.sync2.aux_6v_rail_uv;
    rail_set[supply_fault_pkg::RAIL_DRV_12V_OV_BIT] = st_reg.sync2.driver_12v_rail_ov;
    rail_set[supply_fault_pkg::RAIL_DRV_12V_UV_BIT] = st_reg.sync2.driver_12v_rail_uv;
    rail_set[supply_fault_pkg::RAIL_FLYBACK_OC_BIT] = st_reg.sync2.flyback_oc;
    rail_set[supply_fault_pkg::RAIL_INPUT_OV_BIT]   = st_reg.sync2.input_ov;
    rail_set[supply_fault_pkg::RAIL_BUS_UVLO_BIT]   = st_reg.sync2.low_voltage_bus_uvlo;
    // Reset release itself counts as a power-on event
    rail_set[supply_fault_pkg::RAIL_POR_BIT] = st_reg.por_pend | st_reg.sync2.por_detect;
    regl_set = 8'h00;
    regl_set[supply_fault_pkg::REGL_SUPPLY_WINDOW_BIT] = st_reg.sync2.driver_supply_out_of_window;
    regl_set[supply_fault_pkg::REGL_MICRO_OV_BIT] = st_reg.sync2.micro_linear_regulator_ov;
    regl_set[supply_fault_pkg::REGL_MICRO_UV_BIT] = st_reg.sync2.micro_linear_regulator_uv;
    // Writing 1 keeps a flag, writing 0 clears it; set wins over clear
    rail_keep = wr_rail ? (st_reg.rail & req_in.wdata) : st_reg.rail;
    regl_keep = wr_regl ? (st_reg.regl & req_in.wdata) : st_reg.regl;
    st_next.rail = (rail_keep | rail_set) & supply_fault_pkg::SUPPLY_RAIL_MASK;
    st_next.regl = (regl_keep | regl_set) & supply_fault_pkg::REGULATOR_MASK;
    // Alert follows the flags, so it drops only once software has cleared every one
    st_next.summary = |{st_next.rail, st_next.regl};
    st_next.alert_n = ~st_next.summary;
    if (req_in.rd) begin
      case (req_in.addr)
        supply_fault_pkg::SUPPLY_RAIL_FAULT_STATUS_ADDR: st_next.rdata = st_reg.rail;
        supply_fault_pkg::REGULATOR_FAULT_STATUS_ADDR:   st_next.rdata = st_reg.regl;
        default:                                         st_next.rdata = supply_fault_pkg::READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg          <= '0;
      st_reg.rail     <= supply_fault_pkg::STATUS_RESET;
      st_reg.regl     <= supply_fault_pkg::STATUS_RESET;
      st_reg.por_pend <= 1'b1;
      st_reg.alert_n  <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata_out                    = st_reg.rdata;
  assign supply_rail_fault_status_out = st_reg.rail;
  assign regulator_fault_status_out   = st_reg.regl;
  assign summary_alert_out            = st_reg.summary;
  assign alert_out_n                  = st_reg.alert_n;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_aux6_ov_flag: assert property (fault_in.aux_6v_rail_ov [*3] |=> st_reg.rail[0])
    else $error("6V overvoltage flag not set");
  a_aux6_uv_flag: assert property ($rose(fault_in.aux_6v_rail_uv) |-> ##[1:3] st_reg.rail[1]
    or !fault_in.aux_6v_rail_uv)
    else $error("6V undervoltage flag late");
  a_drv12_ov_flag: assert property (st_reg.sync2.driver_12v_rail_ov |=> st_reg.rail[2])
    else $error("12V overvoltage flag not set");
  a_drv12_uv_flag: assert property (st_reg.sync2.driver_12v_rail_uv |=> st_reg.rail[3])
    else $error("12V undervoltage flag not set");
  a_flyback_oc_flag: assert property (st_reg.sync2.flyback_oc |=> st_reg.rail[4])
    else $error("Flyback overcurrent flag not set");
  a_input_ov_flag: assert property (st_reg.sync2.input_ov |=> st_reg.rail[5])
    else $error("Input overvoltage flag not set");
  a_bus_uvlo_flag: assert property (st_reg.sync2.low_voltage_bus_uvlo |=> st_reg.rail[6])
    else $error("Bus lockout flag not set");
  a_por_after_reset: assert property ($fell(rst_in) |-> ##1 st_reg.rail[7])
    else $error("Power-on flag not set after reset");
  a_supply_window: assert property (st_reg.sync2.driver_supply_out_of_window |=> st_reg.regl[0])
    else $error("Driver supply window flag not set");
  a_micro_ov_flag: assert property (st_reg.sync2.micro_linear_regulator_ov |=> st_reg.regl[4])
    else $error("Regulator overvoltage flag not set");
  a_micro_uv_flag: assert property (st_reg.sync2.micro_linear_regulator_uv |=> st_reg.regl[5])
    else $error("Regulator undervoltage flag not set");
  a_alert_tracks: assert property (alert_out_n == !(|{st_reg.rail, st_reg.regl})
    && summary_alert_out == !alert_out_n)
    else $error("Alert pin disagrees with flags");
  a_sticky_hold: assert property (st_reg.rail[3] && !(req_in.wr
    && req_in.addr == supply_fault_pkg::SUPPLY_RAIL_FAULT_STATUS_ADDR) |=> st_reg.rail[3])
    else $error("Flag dropped without a clearing write");
  a_reserved_zero: assert property ((st_reg.regl & ~supply_fault_pkg::REGULATOR_MASK) == 8'h00)
    else $error("Reserved regulator bit set");
  a_read_rail: assert property (req_in.rd && req_in.addr == supply_fault_pkg::SUPPLY_RAIL_FAULT_STATUS_ADDR
    |=> rdata_out == $past(st_reg.rail))
    else $error("Read data wrong for supply-rail register");

  // Clearing: a 0 written once the condition has gone drops the flag
  a_rail0_clear: assert property (
    wr_rail && !req_in.wdata[0] && !st_reg.sync2.aux_6v_rail_ov
    |=> !st_reg.rail[0])
    else $error("6V overvoltage flag survived a clear");
  a_rail1_clear: assert property (
    wr_rail && !req_in.wdata[1] && !st_reg.sync2.aux_6v_rail_uv
    |=> !st_reg.rail[1])
    else $error("6V undervoltage flag survived a clear");
  a_rail2_clear: assert property (
    wr_rail && !req_in.wdata[2] && !st_reg.sync2.driver_12v_rail_ov
    |=> !st_reg.rail[2])
    else $error("12V overvoltage flag survived a clear");
  a_rail3_clear: assert property (
    wr_rail && !req_in.wdata[3] && !st_reg.sync2.driver_12v_rail_uv
    |=> !st_reg.rail[3])
    else $error("12V undervoltage flag survived a clear");
  a_rail4_clear: assert property (
    wr_rail && !req_in.wdata[4] && !st_reg.sync2.flyback_oc
    |=> !st_reg.rail[4])
    else $error("Flyback overcurrent flag survived a clear");
  a_rail5_clear: assert property (
    wr_rail && !req_in.wdata[5] && !st_reg.sync2.input_ov
    |=> !st_reg.rail[5])
    else $error("Input overvoltage flag survived a clear");
  a_rail6_clear: assert property (
    wr_rail && !req_in.wdata[6] && !st_reg.sync2.low_voltage_bus_uvlo
    |=> !st_reg.rail[6])
    else $error("Bus lockout flag survived a clear");
  a_rail7_clear: assert property (
    wr_rail && !req_in.wdata[7] && !st_reg.sync2.por_detect && !st_reg.por_pend
    |=> !st_reg.rail[7])
    else $error("Power-on flag survived a clear");
  a_regl0_clear: assert property (
    wr_regl && !req_in.wdata[0] && !st_reg.sync2.driver_supply_out_of_window
    |=> !st_reg.regl[0])
    else $error("Driver supply window flag survived a clear");
  a_regl4_clear: assert property (
    wr_regl && !req_in.wdata[4] && !st_reg.sync2.micro_linear_regulator_ov
    |=> !st_reg.regl[4])
    else $error("Regulator overvoltage flag survived a clear");
  a_regl5_clear: assert property (
    wr_regl && !req_in.wdata[5] && !st_reg.sync2.micro_linear_regulator_uv
    |=> !st_reg.regl[5])
    else $error("Regulator undervoltage flag survived a clear");

  // Holding: only a write to its own register may drop a flag
  a_rail0_hold: assert property (
    st_reg.rail[0] && !wr_rail
    |=> st_reg.rail[0])
    else $error("6V overvoltage flag dropped on its own");
  a_rail1_hold: assert property (
    st_reg.rail[1] && !wr_rail
    |=> st_reg.rail[1])
    else $error("6V undervoltage flag dropped on its own");
  a_rail2_hold: assert property (
    st_reg.rail[2] && !wr_rail
    |=> st_reg.rail[2])
    else $error("12V overvoltage flag dropped on its own");
  a_rail4_hold: assert property (
    st_reg.rail[4] && !wr_rail
    |=> st_reg.rail[4])
    else $error("Flyback overcurrent flag dropped on its own");
  a_rail5_hold: assert property (
    st_reg.rail[5] && !wr_rail
    |=> st_reg.rail[5])
    else $error("Input overvoltage flag dropped on its own");
  a_rail6_hold: assert property (
    st_reg.rail[6] && !wr_rail
    |=> st_reg.rail[6])
    else $error("Bus lockout flag dropped on its own");
  a_rail7_hold: assert property (
    st_reg.rail[7] && !wr_rail
    |=> st_reg.rail[7])
    else $error("Power-on flag dropped on its own");
  a_regl0_hold: assert property (
    st_reg.regl[0] && !wr_regl
    |=> st_reg.regl[0])
    else $error("Driver supply window flag dropped on its own");
  a_regl4_hold: assert property (
    st_reg.regl[4] && !wr_regl
    |=> st_reg.regl[4])
    else $error("Regulator overvoltage flag dropped on its own");
  a_regl5_hold: assert property (
    st_reg.regl[5] && !wr_regl
    |=> st_reg.regl[5])
    else $error("Regulator undervoltage flag dropped on its own");

  // Quiet: no condition, no flag, whatever the host writes
  a_rail0_quiet: assert property (
    !st_reg.rail[0] && !st_reg.sync2.aux_6v_rail_ov
    |=> !st_reg.rail[0])
    else $error("6V overvoltage flag set with no fault");
  a_rail1_quiet: assert property (
    !st_reg.rail[1] && !st_reg.sync2.aux_6v_rail_uv
    |=> !st_reg.rail[1])
    else $error("6V undervoltage flag set with no fault");
  a_rail2_quiet: assert property (
    !st_reg.rail[2] && !st_reg.sync2.driver_12v_rail_ov
    |=> !st_reg.rail[2])
    else $error("12V overvoltage flag set with no fault");
  a_rail3_quiet: assert property (
    !st_reg.rail[3] && !st_reg.sync2.driver_12v_rail_uv
    |=> !st_reg.rail[3])
    else $error("12V undervoltage flag set with no fault");
  a_rail4_quiet: assert property (
    !st_reg.rail[4] && !st_reg.sync2.flyback_oc
    |=> !st_reg.rail[4])
    else $error("Flyback overcurrent flag set with no fault");
  a_rail5_quiet: assert property (
    !st_reg.rail[5] && !st_reg.sync2.input_ov
    |=> !st_reg.rail[5])
    else $error("Input overvoltage flag set with no fault");
  a_rail6_quiet: assert property (
    !st_reg.rail[6] && !st_reg.sync2.low_voltage_bus_uvlo
    |=> !st_reg.rail[6])
    else $error("Bus lockout flag set with no fault");
  a_rail7_quiet: assert property (
    !st_reg.rail[7] && !st_reg.sync2.por_detect && !st_reg.por_pend
    |=> !st_reg.rail[7])
    else $error("Power-on flag set with no event");
  a_regl0_quiet: assert property (
    !st_reg.regl[0] && !st_reg.sync2.driver_supply_out_of_window
    |=> !st_reg.regl[0])
    else $error("Driver supply window flag set with no fault");
  a_regl4_quiet: assert property (
    !st_reg.regl[4] && !st_reg.sync2.micro_linear_regulator_ov
    |=> !st_reg.regl[4])
    else $error("Regulator overvoltage flag set with no fault");
  a_regl5_quiet: assert property (
    !st_reg.regl[5] && !st_reg.sync2.micro_linear_regulator_uv
    |=> !st_reg.regl[5])
    else $error("Regulator undervoltage flag set with no fault");

  // Read path, address decode and alert pin
  a_read_regl: assert property (
    req_in.rd && req_in.addr == supply_fault_pkg::REGULATOR_FAULT_STATUS_ADDR
    |=> rdata_out == $past(st_reg.regl))
    else $error("Read data wrong for regulator register");
  a_read_unmapped: assert property (
    req_in.rd && !wr_rail && !wr_regl && req_in.addr != supply_fault_pkg::SUPPLY_RAIL_FAULT_STATUS_ADDR
    && req_in.addr != supply_fault_pkg::REGULATOR_FAULT_STATUS_ADDR |=> rdata_out == 8'h00)
    else $error("Unmapped read returned data");
  a_rdata_hold: assert property (
    !req_in.rd
    |=> $stable(rdata_out))
    else $error("Read data changed without a read");
  a_rail_own_addr: assert property (
    !wr_rail
    |=> (st_reg.rail & $past(st_reg.rail)) == $past(st_reg.rail))
    else $error("Supply-rail flag lost without its own write");
  a_regl_own_addr: assert property (
    !wr_regl
    |=> (st_reg.regl & $past(st_reg.regl)) == $past(st_reg.regl))
    else $error("Regulator flag lost without its own write");
  a_rd_keeps_flags: assert property (
    req_in.rd && !req_in.wr
    |=> (st_reg.rail & $past(st_reg.rail)) == $past(st_reg.rail))
    else $error("Read cleared a flag");
  a_rail_write_ones: assert property (
    wr_rail && req_in.wdata == 8'hFF
    |=> (st_reg.rail & $past(st_reg.rail)) == $past(st_reg.rail))
    else $error("Writing ones cleared a supply-rail flag");
  a_regl_write_ones: assert property (
    wr_regl && req_in.wdata == 8'hFF
    |=> (st_reg.regl & $past(st_reg.regl)) == $past(st_reg.regl))
    else $error("Writing ones cleared a regulator flag");
  a_por_pend_once: assert property (
    st_reg.por_pend
    |=> !st_reg.por_pend)
    else $error("Power-on event held past its first cycle");
  // Pin must not flicker while software is still reading the cause
  a_alert_stays: assert property (
    !alert_out_n && !wr_rail && !wr_regl
    |=> !alert_out_n)
    else $error("Alert released without a clearing write");
  a_alert_idle: assert property (
    alert_out_n && !(|st_reg.sync2) && !st_reg.por_pend
    |=> alert_out_n)
    else $error("Alert raised with no fault");
  a_summary_stays: assert property (
    summary_alert_out && !wr_rail && !wr_regl
    |=> summary_alert_out)
    else $error("Summary bit dropped without a clearing write");

endmodule : supply_fault_status_regs

// [design/supply_fault_pkg.sv]
// Purpose: Constants and carriers for the supply and regulator fault status registers
// Assumes: One 100 MHz clock; fault comparators arrive asynchronously
// Notes:   Flags are sticky; software clears a flag by writing 0 to it
//
// Contract
// - Supply-rail fault register at 0xD3, eight read/write bits, resets to 00h.
// - Bit 0 of supply-rail register sets on 6V auxiliary rail overvoltage.
// - Bit 1 of supply-rail register sets on 6V auxiliary rail undervoltage.
// - Bit 2 of supply-rail register sets on 12V driver rail overvoltage.
// - Bit 3 of supply-rail register sets on 12V driver rail undervoltage.
// - Bit 4 of supply-rail register sets on flyback primary switch overcurrent.
// - Bit 5 of supply-rail register sets on controller input overvoltage.
// - Bit 6 of supply-rail register sets when low-voltage bus falls below lockout.
// - Bit 7 of supply-rail register sets on power-on reset; control registers need reloading.
// - Regulator fault register at 0xD4, resets 00h, bits 1-3 and 6-7 reserved.
// - Regulator bit 0 sets when driver supply leaves its 4.8V to 5.6V window.
// - Regulator bit 4 sets on micro linear regulator overvoltage.
// - Regulator bit 5 sets on micro linear regulator undervoltage.
// - Any fault sets summary bit 7 and pulls the active-low alert pin low; the code gives summary as its own summary_alert_out output, in no register bit.
package supply_fault_pkg;

  localparam logic [7:0] SUPPLY_RAIL_FAULT_STATUS_ADDR = 8'hD3;
  localparam logic [7:0] REGULATOR_FAULT_STATUS_ADDR   = 8'hD4;
  localparam logic [7:0] STATUS_RESET                  = 8'h00;
  localparam logic [7:0] SUPPLY_RAIL_MASK              = 8'hFF;
  localparam logic [7:0] REGULATOR_MASK                = 8'h31;
  localparam logic [7:0] READ_UNMAPPED                 = 8'h00;

  localparam int RAIL_AUX_6V_OV_BIT      = 0;
  localparam int RAIL_AUX_6V_UV_BIT      = 1;
  localparam int RAIL_DRV_12V_OV_BIT     = 2;
  localparam int RAIL_DRV_12V_UV_BIT     = 3;
  localparam int RAIL_FLYBACK_OC_BIT     = 4;
  localparam int RAIL_INPUT_OV_BIT       = 5;
  localparam int RAIL_BUS_UVLO_BIT       = 6;
  localparam int RAIL_POR_BIT            = 7;
  localparam int REGL_SUPPLY_WINDOW_BIT  = 0;
  localparam int REGL_MICRO_OV_BIT       = 4;
  localparam int REGL_MICRO_UV_BIT       = 5;

  // Raw comparator outputs, high while the condition holds
  typedef struct packed {
    logic aux_6v_rail_ov;
    logic aux_6v_rail_uv;
    logic driver_12v_rail_ov;
    logic driver_12v_rail_uv;
    logic flyback_oc;
    logic input_ov;
    logic low_voltage_bus_uvlo;
    logic por_detect;
    logic driver_supply_out_of_window;
    logic micro_linear_regulator_ov;
    logic micro_linear_regulator_uv;
  } fault_cond_s;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [7:0]  rail;
    logic [7:0]  regl;
    logic [7:0]  rdata;
    fault_cond_s sync1;
    fault_cond_s sync2;
    logic        por_pend;
    logic        alert_n;
    logic        summary;
  } fault_state_s;

endpackage : supply_fault_pkg

// [tb/host_bus_model.sv]
// Purpose: Host side of the register port, one request every two cycles
// Assumes: Each call starts just after a rising edge
// Notes:   Control registers outside this block are addressed only, not modelled
`timescale 1ns/100ps
module host_bus_model (
  input  wire logic                  sys_clk_in,
  input  wire logic [7:0]            rdata_in,
  output supply_fault_pkg::reg_req_s req_out
);
  initial req_out = '0;
  // Idle cycle after each request, so no strobe is driven twice in one step
  task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
    req_out = '{addr: a, wr: w, rd: !w, wdata: d};
    @(posedge sys_clk_in);
    #1;
    q = rdata_in;
    req_out = '0;
    @(posedge sys_clk_in);
    #1;
  endtask : access
  // Reload control settings first, drop the power-on flag last
  task automatic reload_after_por(input int n);
    logic [7:0] q;
    for (int i = 0; i < n; i++) access(8'h20 + 8'(i), 1'b1, 8'hA5, q);
    access(8'hD3, 1'b1, 8'h7F, q);
  endtask : reload_after_por
endmodule : host_bus_model

// [tb/test_supply_fault_status_regs.sv]
// Purpose: Self-checking bench for the fault status registers
// Assumes: Flags appear three edges after a comparator rises
// Notes:   Random writes are made with no fault pending
`timescale 1ns/100ps
module test_supply_fault_status_regs;
  `define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
  logic                          sys_clk_in = 1'b0;
  logic                          rst_in     = 1'b1;
  supply_fault_pkg::fault_cond_s fault_in   = '0;
  supply_fault_pkg::reg_req_s    req_bus;
  logic [7:0]                    rdata, rail, regl, q;
  logic                          summary, alert_n;
  logic [31:0]                   lfsr       = 32'h00016930;
  int                            bad_count  = 0;
  int                            cmp_count  = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  supply_fault_status_regs i_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .fault_in(fault_in), .req_in(req_bus),
    .rdata_out(rdata), .supply_rail_fault_status_out(rail), .regulator_fault_status_out(regl),
    .summary_alert_out(summary), .alert_out_n(alert_n));
  host_bus_model i_host (.sys_clk_in(sys_clk_in), .rdata_in(rdata), .req_out(req_bus));
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand
  // Expected {regulator, rail} flag for comparator k of the packed struct
  function automatic logic [15:0] flag_of(input int k);
    return (k >= 3) ? 16'h0001 << (10 - k) : 16'h0100 << ((k == 2) ? 0 : 5 - k);
  endfunction : flag_of
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : tick
  task automatic summarize();
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    logic [15:0] m;
    logic [7:0]  a;
    tick(3);
    `CHK("rail_rst", 8'h00, rail)
    `CHK("regl_rst", 8'h00, regl)
    `CHK("alert_rst", 1'b1, alert_n)
    rst_in = 1'b0;
    tick(1);
    `CHK("por_flag", 8'h80, rail)
    `CHK("summary", 1'b1, summary)
    `CHK("alert_por", 1'b0, alert_n)
    i_host.access(8'hD3, 1'b1, 8'hFF, q);
    `CHK("por_w1", 8'h80, rail)
    i_host.reload_after_por(4);
    `CHK("por_clear", 8'h00, rail)
    `CHK("alert_idle", 1'b1, alert_n)
    for (int k = 0; k < 11; k++) begin
      m = flag_of(k);
      a = (m[7:0] != 8'h00) ? 8'hD3 : 8'hD4;
      fault_in = supply_fault_pkg::fault_cond_s'(11'h001 << k);
      tick(2);
      `CHK("flag_early", 16'h0000, {regl, rail})
      tick(1);
      `CHK("flag_set", m, {regl, rail})
      `CHK("alert_set", 1'b0, alert_n)
      // Clear while the condition still holds must lose
      i_host.access(a, 1'b1, 8'h00, q);
      `CHK("set_wins", m, {regl, rail})
      i_host.access(a, 1'b0, 8'h00, q);
      `CHK("rd_set", m[7:0] | m[15:8], q)
      fault_in = '0;
      lfsr = next_rand(lfsr);
      i_host.access(a, 1'b1, lfsr[7:0] | m[7:0] | m[15:8], q);
      `CHK("w1_keep", m, {regl, rail})
      // Zero to the other register must leave this flag alone
      i_host.access(a ^ 8'h07, 1'b1, 8'h00, q);
      `CHK("other_reg", m, {regl, rail})
      i_host.access(a, 1'b1, ~(m[7:0] | m[15:8]), q);
      i_host.access(a, 1'b0, 8'h00, q);
      `CHK("rd_clear", 8'h00, q)
      `CHK("alert_clr", 1'b1, alert_n)
    end
    repeat (24) begin
      lfsr = next_rand(lfsr);
      a = (lfsr[9:8] == 2'h0) ? 8'hD4 : (lfsr[9:8] == 2'h1) ? 8'hD3 : lfsr[23:16];
      i_host.access(a, 1'b1, lfsr[7:0], q);
      i_host.access(a, 1'b0, 8'h00, q);
      `CHK("rd_back", 8'h00, q)
    end
    rst_in = 1'b1;
    tick(1);
    `CHK("rerst", 8'h00, rail)
    rst_in = 1'b0;
    tick(1);
    `CHK("por_again", 8'h80, rail)
    summarize();
  end
  initial begin
    #100000;
    bad_count++;
    summarize();
  end
endmodule : test_supply_fault_status_regs
